// file: core/mmc_measure_control.sv
`timescale 1ns/1ps
module mmc_measure_control
	import mmc_pkg::*;
#(
	parameter mmc_pkg::mmc_variant_t VARIANT    = MMC_VAR_SEVEN,
	parameter bit                    RANGE_700  = 1'b0,
	parameter bit                    MODEL_1KPA = 1'b0,
	parameter bit                    MULTIMETER = 1'b0,
	parameter int unsigned           EXT_FILTER = EXT_MIN_CYC,
	parameter int unsigned           MS_CYCLES  = CYC_PER_MS
)
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Avalon-MM slave
	input  wire logic [7:0]        i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	output logic [31:0]            o_avs_readdata,
	output logic                   o_avs_waitrequest,
	// Sensor
	input  wire logic signed [31:0] i_pressure,
	input  wire logic              i_pressure_valid,
	// External lines
	input  wire logic              i_external_measure_request,
	// Indicators and outputs
	output logic                   o_hold_led,
	output logic                   o_sample_led,
	output logic                   o_relative_led,
	output logic                   o_over_maximum_flag,
	output logic                   o_in_band,
	output logic                   o_under_minimum_flag,
	output logic                   o_cmp_changed,
	output logic [15:0]            o_da_code,
	output logic                   o_da_strobe
);
	import mmc_pkg::*;

	localparam int unsigned GAP_W = 32;

	function automatic logic [GAP_W-1:0] ms_to_cyc(input int unsigned ms);
		ms_to_cyc = GAP_W'(ms * MS_CYCLES);
	endfunction : ms_to_cyc

	// ============================================================
	// Bus slave
	logic [31:0]   ctrl_ff;
	logic signed [31:0] hi_lim_ff;
	logic signed [31:0] lo_lim_ff;
	logic          ack_ff;
	logic          bus_req;
	logic          wr_en;
	logic [5:0]    key;
	logic          pct_mode;
	mmc_avm_req_t  req;

	assign req      = '{address: i_avs_address, read: i_avs_read,
		write: i_avs_write, writedata: i_avs_writedata};
	assign bus_req  = req.read || req.write;
	// One wait cycle; writes land as waitrequest drops
	assign o_avs_waitrequest = bus_req && !ack_ff;
	assign wr_en    = req.write && ack_ff;
	assign key      = (wr_en && req.address == ADDR_KEYS) ? req.writedata[5:0] : 6'h00;
	assign pct_mode = ctrl_ff[CTRL_PCT] || ctrl_ff[CTRL_PCT_ERR];

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= bus_req && !ack_ff;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			ctrl_ff <= CTRL_RESET;
		else if (wr_en && req.address == ADDR_CTRL)
		begin
			ctrl_ff <= req.writedata & 32'h0000_0FFF;
			// Enable bit only writable on DC or battery power
			if (req.writedata[CTRL_AC_PWR])
				ctrl_ff[CTRL_DA_EN] <= ctrl_ff[CTRL_DA_EN];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			hi_lim_ff <= '0;
			lo_lim_ff <= '0;
		end
		else if (wr_en && req.address == ADDR_HI_LIM)
			hi_lim_ff <= req.writedata;
		else if (wr_en && req.address == ADDR_LO_LIM)
			lo_lim_ff <= req.writedata;
	end

	// ============================================================
	// Unit, mask, relative, hold
	mmc_unit_t     unit_ff;
	mmc_unit_t     nxt_unit;
	logic          mask_ff;
	logic          rel_ff;
	logic          hold_ff;
	logic signed [31:0] ref_ff;
	logic signed [31:0] meas_ff;

	always_comb
	begin
		nxt_unit = unit_ff;
		case (VARIANT)
			MMC_VAR_FOUR:
				nxt_unit = (unit_ff >= MMC_U_MMHG) ? MMC_U_KPA : mmc_unit_t'(unit_ff + 3'h1);
			MMC_VAR_SEVEN:
				nxt_unit = (unit_ff >= MMC_U_PSI) ? MMC_U_KPA : mmc_unit_t'(unit_ff + 3'h1);
			default:
				nxt_unit = MMC_U_KPA;
		endcase
	end

	// Keys stay live during hold
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			unit_ff <= MMC_U_KPA;
		else if (key[KEY_UNIT] && !pct_mode)
			unit_ff <= nxt_unit;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			mask_ff <= 1'b0;
		else if (key[KEY_MASK])
			mask_ff <= !mask_ff;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst || pct_mode)
			rel_ff <= 1'b0;
		else if (key[KEY_REL])
			rel_ff <= !rel_ff;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			ref_ff <= '0;
		else if (key[KEY_REL] && !pct_mode && !rel_ff)
			ref_ff <= meas_ff;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			hold_ff <= 1'b0;
		else if (key[KEY_HOLD])
			hold_ff <= !hold_ff;
	end

	// ============================================================
	// External trigger: sync, then 2 ms low filter
	logic        ext_s1_ff;
	logic        ext_s2_ff;
	logic [17:0] ext_cnt_ff;
	logic        ext_fired_ff;
	logic        ext_measure_request_key;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ext_s1_ff <= 1'b1;
			ext_s2_ff <= 1'b1;
		end
		else
		begin
			ext_s1_ff <= i_external_measure_request;
			ext_s2_ff <= ext_s1_ff;
		end
	end

	// Fires once per falling edge held long enough
	assign ext_measure_request_key = !ext_s2_ff && !ext_fired_ff && (ext_cnt_ff == 18'(EXT_FILTER - 1));

	always_ff @(posedge i_clock)
	begin
		if (i_rst || ext_s2_ff)
		begin
			ext_cnt_ff   <= '0;
			ext_fired_ff <= 1'b0;
		end
		else if (ext_measure_request_key)
			ext_fired_ff <= 1'b1;
		else if (!ext_fired_ff)
			ext_cnt_ff <= ext_cnt_ff + 18'h1;
	end

	// ============================================================
	// Triggered sampling
	logic            measure_request_key;
	logic [GAP_W-1:0] min_gap;
	logic [GAP_W-1:0] gap_cnt_ff;
	logic            too_soon_ff;
	mmc_state_t      state_ff;
	mmc_mode_t       mode;

	assign mode = mmc_mode_t'(ctrl_ff[CTRL_MODE_LO +: 2]);
	assign measure_request_key = hold_ff && (key[KEY_MEASURE_REQUEST_KEY] || key[KEY_REMOTE] || ext_measure_request_key);

	always_comb
	begin
		min_gap = ms_to_cyc(GAP_NORM_RAW_MS);
		if (MODEL_1KPA)
		begin
			if (ctrl_ff[CTRL_SLOW])
				min_gap = ms_to_cyc(GAP_SLOW_RATE_MS);
			else if (ctrl_ff[CTRL_AVG])
				min_gap = ms_to_cyc(GAP_FAST_AVG_MS);
			else
				min_gap = ms_to_cyc(GAP_NORM_RAW_MS);
		end
		else if (MULTIMETER && ctrl_ff[CTRL_DMM_ON])
		begin
			if (ctrl_ff[CTRL_DMM_AVG])
				min_gap = ms_to_cyc(GAP_DMM_AVG_MS);
			else if (ctrl_ff[CTRL_AVG])
				min_gap = ms_to_cyc(GAP_NORM_AVG_MS);
			else
				min_gap = ms_to_cyc(GAP_DMM_RAW_MS);
		end
		else if (MULTIMETER)
			min_gap = ctrl_ff[CTRL_AVG] ? ms_to_cyc(GAP_NORM_AVG_MS)
				: ms_to_cyc(GAP_DMM_RAW_MS);
		else
		begin
			case (mode)
				MMC_MODE_MEDIUM: min_gap = ms_to_cyc(GAP_MEDIUM_MS);
				MMC_MODE_HIGH:   min_gap = ms_to_cyc(GAP_HIGH_MS);
				default:         min_gap = ctrl_ff[CTRL_AVG] ? ms_to_cyc(GAP_NORM_AVG_MS)
					: ms_to_cyc(GAP_NORM_RAW_MS);
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			gap_cnt_ff <= '1;
		else if (measure_request_key)
			gap_cnt_ff <= '0;
		else if (gap_cnt_ff != '1)
			gap_cnt_ff <= gap_cnt_ff + 1'b1;
	end

	// A trigger too close to the last blocks this measurement's update
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			too_soon_ff <= 1'b0;
		else if (measure_request_key)
			too_soon_ff <= (gap_cnt_ff < min_gap);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst || !hold_ff)
			state_ff <= MMC_S_IDLE;
		else
		begin
			case (state_ff)
				MMC_S_IDLE:   if (measure_request_key) state_ff <= MMC_S_SAMPLE;
				MMC_S_SAMPLE: if (!measure_request_key && i_pressure_valid) state_ff <= MMC_S_DONE;
				MMC_S_DONE:   state_ff <= measure_request_key ? MMC_S_SAMPLE : MMC_S_IDLE;
				default:      state_ff <= MMC_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			meas_ff <= '0;
		else if (!hold_ff && i_pressure_valid)
			meas_ff <= i_pressure;
		else if (hold_ff && state_ff == MMC_S_SAMPLE && !measure_request_key && i_pressure_valid
			&& !too_soon_ff)
			meas_ff <= i_pressure;
	end

	// ============================================================
	// Display value, analogue output, comparator
	logic signed [31:0] disp;
	logic [2:0]   digits;
	logic [15:0]  da_ff;
	logic         da_strobe_ff;
	logic         cmp_tick;
	mmc_cmp_t     cmp;

	assign disp = rel_ff ? (meas_ff - ref_ff) : meas_ff;
	// Digit count counted in whole digits beside the half digit
	assign digits = RANGE_700 ? (mask_ff ? 3'h3 : 3'h4)
		: (mask_ff ? 3'h4 : 3'h5);

	mmc_comparator #(.PERIOD(CONV_TIME_US / 1000 * MS_CYCLES)) u_cmp (
		.i_clock    (i_clock),
		.i_rst      (i_rst),
		.i_enable   (ctrl_ff[CTRL_CMP_EN]),
		.i_value    (disp),
		.i_hi_limit (hi_lim_ff),
		.i_lo_limit (lo_lim_ff),
		.o_tick     (cmp_tick),
		.o_result   (cmp),
		.o_changed  (o_cmp_changed)
	);

	// Scale kept simple: 5 V range halves the code per count
	always_ff @(posedge i_clock)
	begin
		if (i_rst || !ctrl_ff[CTRL_DA_EN])
			da_ff <= '0;
		else if (cmp_tick)
			da_ff <= ctrl_ff[CTRL_DA_5V] ? disp[16:1] : disp[15:0];
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			da_strobe_ff <= 1'b0;
		else
			da_strobe_ff <= cmp_tick && ctrl_ff[CTRL_DA_EN];
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_avs_readdata <= '0;
		else if (req.read && !ack_ff)
		begin
			case (req.address)
				ADDR_CTRL:   o_avs_readdata <= ctrl_ff;
				ADDR_STATUS: o_avs_readdata <= {20'h0, digits, unit_ff, cmp,
					state_ff == MMC_S_SAMPLE, rel_ff, hold_ff};
				ADDR_PRESS:  o_avs_readdata <= meas_ff;
				ADDR_REF:    o_avs_readdata <= ref_ff;
				ADDR_HI_LIM: o_avs_readdata <= hi_lim_ff;
				ADDR_LO_LIM: o_avs_readdata <= lo_lim_ff;
				ADDR_DISP:   o_avs_readdata <= disp;
				default:     o_avs_readdata <= '0;
			endcase
		end
	end

	assign o_hold_led           = hold_ff;
	assign o_sample_led         = (state_ff == MMC_S_SAMPLE);
	assign o_relative_led       = rel_ff;
	assign o_over_maximum_flag  = cmp.over_maximum_flag;
	assign o_in_band            = cmp.in_band;
	assign o_under_minimum_flag = cmp.under_minimum_flag;
	assign o_da_code            = da_ff;
	assign o_da_strobe          = da_strobe_ff;

	// ============================================================
	// Checks
	unit_reset_a: assert property (@(posedge i_clock) $fell(i_rst) |-> unit_ff == MMC_U_KPA)
		else $error("unit not kPa after reset");
	unit_pct_a: assert property (@(posedge i_clock) disable iff (i_rst)
		pct_mode && !$past(i_rst) |=> $stable(unit_ff))
		else $error("unit changed in percentage mode");
	mask_toggle_a: assert property (@(posedge i_clock) disable iff (i_rst)
		key[KEY_MASK] |=> mask_ff != $past(mask_ff))
		else $error("mask did not toggle");
	rel_pct_a: assert property (@(posedge i_clock) disable iff (i_rst)
		pct_mode |=> !rel_ff)
		else $error("relative on in percentage mode");
	measure_request_key_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!hold_ff && key[KEY_MEASURE_REQUEST_KEY] |=> !o_sample_led)
		else $error("trigger accepted outside hold");
	sample_led_a: assert property (@(posedge i_clock) disable iff (i_rst)
		measure_request_key ##1 hold_ff |-> o_sample_led)
		else $error("sample led not lit after trigger");
	held_value_a: assert property (@(posedge i_clock) disable iff (i_rst)
		hold_ff && $past(hold_ff) && state_ff != MMC_S_DONE |-> $stable(meas_ff))
		else $error("held value moved");
	cmp_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!$past(ctrl_ff[CTRL_CMP_EN]) |-> cmp == '0)
		else $error("comparator output while disabled");
	cmp_onehot_a: assert property (@(posedge i_clock) disable iff (i_rst)
		ctrl_ff[CTRL_CMP_EN] && $past(cmp_tick) && $past(ctrl_ff[CTRL_CMP_EN])
		|-> $onehot(cmp))
		else $error("comparator result not one-hot");
	da_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
		$past(!ctrl_ff[CTRL_DA_EN]) |-> da_ff == '0)
		else $error("analogue output while disabled");

	hold_cov: cover property (@(posedge i_clock) disable iff (i_rst) $rose(hold_ff));
	retrig_cov: cover property (@(posedge i_clock) disable iff (i_rst)
		state_ff == MMC_S_SAMPLE && measure_request_key);
	rel_cov: cover property (@(posedge i_clock) disable iff (i_rst) $rose(rel_ff));
	cmp_cov: cover property (@(posedge i_clock) disable iff (i_rst) o_cmp_changed);

endmodule : mmc_measure_control

// file: core/mmc_pkg.sv
package mmc_pkg;

	// ============================================================
	// Clock and time
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned CONV_TIME_US  = 2000;
	localparam int unsigned CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;
	localparam int unsigned EXT_MIN_US    = 2000;
	localparam int unsigned EXT_MIN_CYC   = EXT_MIN_US * CLK_MHZ;

	// ============================================================
	// Minimum trigger intervals in ms
	localparam int unsigned GAP_NORM_AVG_MS   = 1600;
	localparam int unsigned GAP_NORM_RAW_MS   = 260;
	localparam int unsigned GAP_MEDIUM_MS     = 110;
	localparam int unsigned GAP_HIGH_MS       = 80;
	localparam int unsigned GAP_DMM_AVG_MS    = 2500;
	localparam int unsigned GAP_DMM_RAW_MS    = 500;
	localparam int unsigned GAP_SLOW_RATE_MS  = 4100;
	localparam int unsigned GAP_FAST_AVG_MS   = 2600;
	localparam int unsigned CYC_PER_MS        = CLK_MHZ * 1000;

	// ============================================================
	// Avalon register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_KEYS   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_PRESS  = 8'h0C;
	localparam logic [7:0] ADDR_REF    = 8'h10;
	localparam logic [7:0] ADDR_HI_LIM = 8'h14;
	localparam logic [7:0] ADDR_LO_LIM = 8'h18;
	localparam logic [7:0] ADDR_DISP   = 8'h1C;

	// CTRL field positions
	localparam int unsigned CTRL_PCT     = 0;
	localparam int unsigned CTRL_PCT_ERR = 1;
	localparam int unsigned CTRL_DA_EN   = 2;
	localparam int unsigned CTRL_DA_5V   = 3;
	localparam int unsigned CTRL_CMP_EN  = 4;
	localparam int unsigned CTRL_AVG     = 5;
	localparam int unsigned CTRL_DMM_ON  = 6;
	localparam int unsigned CTRL_DMM_AVG = 7;
	localparam int unsigned CTRL_MODE_LO = 8;
	localparam int unsigned CTRL_SLOW    = 10;
	localparam int unsigned CTRL_AC_PWR  = 11;

	// KEYS write-one pulse positions
	localparam int unsigned KEY_UNIT = 0;
	localparam int unsigned KEY_MASK = 1;
	localparam int unsigned KEY_REL  = 2;
	localparam int unsigned KEY_HOLD = 3;
	localparam int unsigned KEY_MEASURE_REQUEST_KEY = 4;
	localparam int unsigned KEY_REMOTE = 5;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		MMC_VAR_SINGLE = 2'h0,
		MMC_VAR_FOUR   = 2'h1,
		MMC_VAR_SEVEN  = 2'h2
	} mmc_variant_t;

	typedef enum logic [1:0] {
		MMC_MODE_NORMAL = 2'h0,
		MMC_MODE_MEDIUM = 2'h1,
		MMC_MODE_HIGH   = 2'h2
	} mmc_mode_t;

	typedef enum logic [2:0] {
		MMC_U_KPA  = 3'h0,
		MMC_U_KGF  = 3'h1,
		MMC_U_MMH2O = 3'h2,
		MMC_U_MMHG = 3'h3,
		MMC_U_INH2O = 3'h4,
		MMC_U_INHG = 3'h5,
		MMC_U_PSI  = 3'h6
	} mmc_unit_t;

	typedef enum logic [1:0] {
		MMC_S_IDLE   = 2'b00,
		MMC_S_SAMPLE = 2'b01,
		MMC_S_DONE   = 2'b11
	} mmc_state_t;

	typedef struct packed {
		logic over_maximum_flag;
		logic in_band;
		logic under_minimum_flag;
	} mmc_cmp_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} mmc_avm_req_t;

endpackage : mmc_pkg

// file: core/mmc_comparator.sv
`timescale 1ns/1ps
module mmc_comparator
	import mmc_pkg::*;
#(
	parameter int unsigned PERIOD = CONV_CYCLES
)
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Control
	input  wire logic              i_enable,
	input  wire logic signed [31:0] i_value,
	input  wire logic signed [31:0] i_hi_limit,
	input  wire logic signed [31:0] i_lo_limit,
	// Results
	output logic                   o_tick,
	output mmc_pkg::mmc_cmp_t      o_result,
	output logic                   o_changed
);
	import mmc_pkg::*;

	logic [17:0] period_ff;
	mmc_cmp_t    result_ff;
	mmc_cmp_t    nxt_result;
	logic        changed_ff;
	logic        tick;

	// Parent scales the period with its own cycles per ms
	assign tick = (period_ff == 18'(PERIOD - 1));

	// ============================================================
	// Conversion period counter
	always_ff @(posedge i_clock)
	begin
		if (i_rst || tick)
			period_ff <= '0;
		else
			period_ff <= period_ff + 18'h1;
	end

	always_comb
	begin
		nxt_result = '0;
		if (i_value > i_hi_limit)
			nxt_result.over_maximum_flag = 1'b1;
		else if (i_value < i_lo_limit)
			nxt_result.under_minimum_flag = 1'b1;
		else
			nxt_result.in_band = 1'b1;
	end

	// ============================================================
	// Classification once per conversion
	always_ff @(posedge i_clock)
	begin
		if (i_rst || !i_enable)
			result_ff <= '0;
		else if (tick)
			result_ff <= nxt_result;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			changed_ff <= 1'b0;
		else
			changed_ff <= tick && i_enable && (nxt_result != result_ff);
	end

	assign o_tick    = tick;
	assign o_result  = result_ff;
	assign o_changed = changed_ff;

endmodule : mmc_comparator

// file: sim/mmc_far_side_model.sv
`timescale 1ns/1ps
module mmc_far_side_model
(
	// Clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	// Level set by the bench
	input  wire logic signed [31:0] i_level,
	// Lines to the block
	output logic signed [31:0]      o_pressure,
	output logic                    o_pressure_valid,
	output logic                    o_external_measure_request
);
	// ============================================================
	// Sensor, one sample every 32 cycles
	logic [4:0] cnt_ff;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			cnt_ff <= 5'h00;
		else
			cnt_ff <= cnt_ff + 5'h01;
	end

	assign o_pressure_valid = (cnt_ff == 5'h1F);
	// Junk between samples so a stale value cannot pass
	assign o_pressure = o_pressure_valid ? i_level : ~i_level;

	// ============================================================
	// External trigger line, idle high
	initial o_external_measure_request = 1'b1;

	// Bench decides how long the line stays low
	task automatic ext_drive(input logic lvl);
		@(posedge i_clock);
		o_external_measure_request <= lvl;
	endtask : ext_drive
endmodule : mmc_far_side_model

// file: sim/manometer_measure_control_tb_top.sv
`timescale 1ns/1ps
module manometer_measure_control_tb_top;
	import mmc_pkg::*;
	// ============================================================
	// Signals
	logic               i_clock = 1'b0;
	logic               i_rst = 1'b1;
	logic [7:0]         avs_address = 8'h00;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic [31:0]        avs_writedata = 32'h0;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic signed [31:0] level = 32'sh10;
	logic signed [31:0] pressure;
	logic               pressure_valid;
	logic               ext_req;
	logic [5:0]         leds;
	logic               cmp_chg;
	logic               da_strobe;
	logic [15:0]        da_code;
	logic [31:0]        rd;
	int                 error_cnt = 0;
	int                 comparisons = 0;

	always #5 i_clock = ~i_clock;

	// Short counts so the trigger interval fits the run
	mmc_measure_control #(.EXT_FILTER(20), .MS_CYCLES(10)) i_dut (
		.i_clock(i_clock), .i_rst(i_rst),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest),
		.i_pressure(pressure), .i_pressure_valid(pressure_valid),
		.i_external_measure_request(ext_req),
		.o_hold_led(leds[5]), .o_sample_led(leds[4]), .o_relative_led(leds[3]),
		.o_over_maximum_flag(leds[2]), .o_in_band(leds[1]), .o_under_minimum_flag(leds[0]),
		.o_cmp_changed(cmp_chg), .o_da_code(da_code), .o_da_strobe(da_strobe));

	mmc_far_side_model i_far (
		.i_clock(i_clock), .i_rst(i_rst), .i_level(level), .o_pressure(pressure),
		.o_pressure_valid(pressure_valid), .o_external_measure_request(ext_req));

	// ============================================================
	// Shared tasks
	task automatic stop_test;
		$display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic fail(input int n);
		if (n >= 400)
		begin
			error_cnt++;
			$display("ERROR %0t: wait ran out", $time);
			stop_test;
		end
	endtask : fail

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 400);
		fail(n);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic key(input int unsigned k);
		bus(1'b1, ADDR_KEYS, 32'h1 << k);
		#1;
	endtask : key

	task automatic wait_sample(input logic v);
		int n;
		n = 0;
		while (leds[4] !== v && n < 400)
		begin
			@(posedge i_clock);
			#1;
			n++;
		end
		fail(n);
	endtask : wait_sample

	task automatic wait_strobe(output int n);
		n = 0;
		do
		begin
			@(posedge i_clock);
			#1;
			n++;
		end
		while (da_strobe !== 1'b1 && n < 400);
		fail(n);
	endtask : wait_strobe

	// ============================================================
	// Scenarios
	task automatic t_reset;
		chk({26'h0, leds}, 32'h0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RESET);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_0A00);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
	endtask : t_reset

	task automatic t_units;
		for (int i = 1; i <= 7; i++)
		begin
			key(KEY_UNIT);
			bus(1'b0, ADDR_STATUS, 32'h0);
			chk({29'h0, rd[8:6]}, i % 7);
		end
		for (int m = 1; m <= 2; m++)
		begin
			bus(1'b1, ADDR_CTRL, m);
			key(KEY_UNIT);
			key(KEY_REL);
			bus(1'b0, ADDR_STATUS, 32'h0);
			chk({29'h0, rd[8:6]}, 32'h0);
			chk({31'h0, leds[3]}, 32'h0);
		end
		bus(1'b1, ADDR_CTRL, 32'h0);
	endtask : t_units

	task automatic t_mask_rel;
		key(KEY_MASK);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk({29'h0, rd[11:9]}, 32'h4);
		key(KEY_MASK);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk({29'h0, rd[11:9]}, 32'h5);
		level <= 32'sh1234;
		repeat (40) @(posedge i_clock);
		key(KEY_REL);
		chk({31'h0, leds[3]}, 32'h1);
		bus(1'b0, ADDR_REF, 32'h0);
		chk(rd, 32'h1234);
		key(KEY_REL);
		chk({31'h0, leds[3]}, 32'h0);
	endtask : t_mask_rel

	task automatic t_trigger;
		int n;
		bus(1'b1, ADDR_CTRL, 32'h200);
		level <= 32'sh10;
		repeat (40) @(posedge i_clock);
		key(KEY_MEASURE_REQUEST_KEY);
		chk({31'h0, leds[4]}, 32'h0);
		key(KEY_HOLD);
		chk({31'h0, leds[5]}, 32'h1);
		level <= 32'sh20;
		repeat (40) @(posedge i_clock);
		bus(1'b0, ADDR_PRESS, 32'h0);
		chk(rd, 32'h10);
		// A pulse shorter than the filter must not trigger
		i_far.ext_drive(1'b0);
		repeat (10) @(posedge i_clock);
		i_far.ext_drive(1'b1);
		repeat (40) @(posedge i_clock);
		bus(1'b0, ADDR_PRESS, 32'h0);
		chk(rd, 32'h10);
		for (int s = 0; s < 3; s++)
		begin
			level <= 32'sh30 + s;
			if (s == 0)
				key(KEY_MEASURE_REQUEST_KEY);
			else if (s == 1)
				key(KEY_REMOTE);
			else
				i_far.ext_drive(1'b0);
			wait_sample(1'b1);
			if (s == 2)
				i_far.ext_drive(1'b1);
			wait_sample(1'b0);
			bus(1'b0, ADDR_PRESS, 32'h0);
			chk(rd, 32'h30 + s);
			repeat (810) @(posedge i_clock);
		end
		level <= 32'sh40;
		n = 0;
		do
		begin
			@(posedge i_clock);
			#1;
			n++;
		end
		while (pressure_valid !== 1'b1 && n < 400);
		fail(n);
		// Both triggers land before the next sensor sample
		key(KEY_MEASURE_REQUEST_KEY);
		repeat (5) @(posedge i_clock);
		key(KEY_MEASURE_REQUEST_KEY);
		chk({31'h0, leds[4]}, 32'h1);
		wait_sample(1'b0);
		bus(1'b0, ADDR_PRESS, 32'h0);
		chk(rd, 32'h32);
		repeat (810) @(posedge i_clock);
		key(KEY_MEASURE_REQUEST_KEY);
		wait_sample(1'b0);
		bus(1'b0, ADDR_PRESS, 32'h0);
		chk(rd, 32'h40);
		key(KEY_HOLD);
		chk({31'h0, leds[5]}, 32'h0);
	endtask : t_trigger

	task automatic t_cmp_da;
		int n;
		int seen;
		logic [31:0] lv [3] = '{32'hC8, 32'h4B, 32'h0A};
		logic [2:0]  ex [3] = '{3'b100, 3'b010, 3'b001};
		bus(1'b1, ADDR_HI_LIM, 32'h64);
		bus(1'b1, ADDR_LO_LIM, 32'h32);
		// Settle the value first so enabling gives one change
		level <= lv[0];
		repeat (40) @(posedge i_clock);
		bus(1'b1, ADDR_CTRL, 32'h10);
		for (int i = 0; i < 3; i++)
		begin
			level <= lv[i];
			seen = 0;
			// Four comparator periods, more than one sensor period plus one comparator period
			repeat (80)
			begin
				@(posedge i_clock);
				#1;
				seen += cmp_chg;
			end
			chk({29'h0, leds[2:0]}, ex[i]);
			chk(seen, 32'h1);
		end
		bus(1'b1, ADDR_CTRL, 32'h0);
		repeat (25) @(posedge i_clock);
		#1;
		chk({29'h0, leds[2:0]}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h804);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk({31'h0, rd[2]}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h0C);
		wait_strobe(n);
		chk({16'h0, da_code}, 32'h5);
		wait_strobe(n);
		chk(n, 32'd20);
	endtask : t_cmp_da

	// ============================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		#1;
		t_reset;
		t_units;
		t_mask_rel;
		t_trigger;
		t_cmp_da;
		stop_test;
	end
endmodule : manometer_measure_control_tb_top
